// file: design/fic_ctrl.sv
// Design decision made here: the plain strobed port.
`include "fic_defs.svh"

// Notes on behaviour
// (RULE_01) Pending request with priority below programmed threshold is not offered to core.
// (RULE_02) Threshold of zero disables threshold masking completely.
// (RULE_03) Threshold keeps only bits 7:5; bits 4:0 read zero, writes ignored.
// (RULE_04) Protected control bit changes only when matching key sits in upper half.
// (RULE_05) Key field is write-only and always reads back zero.
// (RULE_06) One to system-reset bit with third key requests reset; bit self-clears.
// (RULE_07) Writing zero to system-reset bit does nothing.
// (RULE_08) Global status bit 9 shows whether any interrupt is pending.
// (RULE_09) Global status bit 8 shows whether any handler is executing.
// (RULE_10) Nesting limited to two levels; context stack two entries deep.
// (RULE_11) Nesting field reads 0x00 idle, 0x01 level one, 0x03 level two.
// (RULE_12) Channel ID register holds four RW bytes, channel 0 lowest.
// (RULE_13) Channel 0 handler address stores bits 31:1; bit 0 always zero.
// (RULE_14) Channel 0 enable bit in address bit 0, resets to zero.
// (RULE_15) Taken interrupt matching enabled channel 0 gets stored address directly.
module fic_ctrl
    import fic_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [`FIC_AW-1:0] i_addr,
    input wire logic [`FIC_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`FIC_DW-1:0] o_rdata,
    // Highest pending request from the pending/enable logic
    input wire logic i_any_pending,
    input wire logic i_req_valid,
    input wire logic [`FIC_ID_W-1:0] i_req_num,
    input wire logic [`FIC_ID_W-1:0] i_req_prio,
    // Core side
    output logic o_take,
    input wire logic i_core_enter,
    input wire logic i_core_exit,
    output logic o_vec_valid,
    output logic o_vec_direct,
    output logic [`FIC_DW-1:0] o_vec_addr,
    // System reset request and event interrupt
    output logic o_sys_reset_req,
    output logic o_irq
);

    // ==========================================================
    // State
    fic_state_t state_reg;
    fic_state_t state_next;

    logic [`FIC_ID_W-1:0] thr_full;
    logic thr_blocked;
    logic nest_full;
    logic [`FIC_ID_W-1:0] nest_code;
    logic active;
    logic direct_hit;
    logic [`FIC_EV_W-1:0] ev_set;
    logic wr_thr;
    logic wr_cfg;
    logic wr_ids;
    logic wr_adr0;
    logic wr_evmk;
    logic rd_evst;
    logic unlock_value_three_ok;
    logic wr_cfg_d;
    logic unlock_value_three_d;
    logic bit7_d;

    // ==========================================================
    // Servicing decision
    // Threshold compares the full 8-bit priority against bits 7:5 padded with zeros
    assign thr_full = {state_reg.thr, `FIC_THR_PAD};
    assign thr_blocked = i_req_valid && (thr_full != `FIC_NEST_NONE)
                         && (i_req_prio < thr_full); // RULE_01 RULE_02
    assign nest_full = (state_reg.nest == FIC_NEST_TWO); // RULE_10
    // Offer is combinational so the core sees it in the same cycle
    assign o_take = i_req_valid && !thr_blocked && !nest_full; // RULE_01 RULE_10
    assign active = (state_reg.nest != FIC_NEST_IDLE);
    // Only channel 0 holds an address here; other channels fall back to the table
    assign direct_hit = state_reg.en0
                        && (i_req_num == state_reg.ids[`FIC_ID_W-1:0]); // RULE_14 RULE_15

    // Nesting status encoding
    always_comb begin
        unique case (state_reg.nest)
            FIC_NEST_IDLE: nest_code = `FIC_NEST_NONE;
            FIC_NEST_ONE: nest_code = `FIC_NEST_L1;
            FIC_NEST_TWO: nest_code = `FIC_NEST_L2; // RULE_11
            default: nest_code = `FIC_NEST_NONE;
        endcase
    end

    // ==========================================================
    // Register decode
    assign wr_thr = i_wr && (i_addr == `FIC_OFF_THR);
    assign wr_cfg = i_wr && (i_addr == `FIC_OFF_CFG);
    assign wr_ids = i_wr && (i_addr == `FIC_OFF_IDS);
    assign wr_adr0 = i_wr && (i_addr == `FIC_OFF_ADR0);
    assign wr_evmk = i_wr && (i_addr == `FIC_OFF_EVMK);
    assign rd_evst = i_rd && (i_addr == `FIC_OFF_EVST);
    assign unlock_value_three_ok = (i_wdata[`FIC_KEY_HI:`FIC_KEY_LO] == `FIC_KEY_THREE); // RULE_04

    // Event sources: new threshold hold-off, direct entry, refusal at full depth
    always_comb begin
        ev_set = `FIC_ZERO_EV;
        ev_set[`FIC_EV_THR] = thr_blocked && !state_reg.blk_prev;
        ev_set[`FIC_EV_DIRECT] = i_core_enter && direct_hit;
        ev_set[`FIC_EV_FULL] = i_core_enter && nest_full;
    end

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.blk_prev = thr_blocked;
        state_next.sw_system_reset_bit = 1'b0; // RULE_06
        state_next.vec_valid = 1'b0;

        // Only bits 7:5 are stored, so 4:0 stay zero for good
        if (wr_thr) begin
            state_next.thr = i_wdata[`FIC_THR_HI:`FIC_THR_LO]; // RULE_03
        end
        // Key one and two guard bits that live elsewhere; only key three acts here
        if (wr_cfg && unlock_value_three_ok && i_wdata[`FIC_SW_SYSTEM_RESET_BIT_BIT]) begin
            state_next.sw_system_reset_bit = 1'b1; // RULE_04 RULE_06 RULE_07
        end
        if (wr_ids) begin
            state_next.ids = i_wdata; // RULE_12
        end
        if (wr_adr0) begin
            state_next.direct_ch0_handler_addr = i_wdata[`FIC_DW-1:1]; // RULE_13
            state_next.en0 = i_wdata[`FIC_EN0_BIT]; // RULE_14
        end
        if (wr_evmk) begin
            state_next.ev_mk = i_wdata[`FIC_EV_W-1:0];
        end

        // Read clears, a simultaneous event still lands
        if (rd_evst) begin
            state_next.ev_st = ev_set;
        end else begin
            state_next.ev_st = state_reg.ev_st | ev_set;
        end

        // Nesting tracker; entering and leaving together keeps the depth
        if (i_core_enter && !i_core_exit) begin
            unique case (state_reg.nest)
                FIC_NEST_IDLE: state_next.nest = FIC_NEST_ONE;
                FIC_NEST_ONE: state_next.nest = FIC_NEST_TWO;
                FIC_NEST_TWO: state_next.nest = FIC_NEST_TWO; // RULE_10
                default: state_next.nest = FIC_NEST_IDLE;
            endcase
        end else if (i_core_exit && !i_core_enter) begin
            unique case (state_reg.nest)
                FIC_NEST_IDLE: state_next.nest = FIC_NEST_IDLE;
                FIC_NEST_ONE: state_next.nest = FIC_NEST_IDLE;
                FIC_NEST_TWO: state_next.nest = FIC_NEST_ONE;
                default: state_next.nest = FIC_NEST_IDLE;
            endcase
        end

        // Vector answer for an accepted entry
        if (i_core_enter && !nest_full) begin
            state_next.vec_valid = 1'b1;
            state_next.vec_direct = direct_hit; // RULE_15
            if (direct_hit) begin
                state_next.vec_addr = {state_reg.direct_ch0_handler_addr, 1'b0}; // RULE_13 RULE_15
            end else begin
                state_next.vec_addr = `FIC_ZERO32;
            end
        end

        // Read data, valid only the cycle after the strobe
        state_next.rdata = `FIC_ZERO32;
        if (i_rd) begin
            unique case (i_addr)
                `FIC_OFF_THR: state_next.rdata[`FIC_THR_HI:`FIC_THR_LO] = state_reg.thr;
                `FIC_OFF_CFG: state_next.rdata = `FIC_ZERO32; // RULE_05
                `FIC_OFF_GSR: begin
                    state_next.rdata[`FIC_GSR_PEND_BIT] = i_any_pending; // RULE_08
                    state_next.rdata[`FIC_GSR_ACT_BIT] = active; // RULE_09
                    state_next.rdata[`FIC_ID_W-1:0] = nest_code; // RULE_11
                end
                `FIC_OFF_IDS: state_next.rdata = state_reg.ids; // RULE_12
                `FIC_OFF_ADR0: state_next.rdata = {state_reg.direct_ch0_handler_addr, state_reg.en0};
                `FIC_OFF_EVST: state_next.rdata[`FIC_EV_W-1:0] = state_reg.ev_st;
                `FIC_OFF_EVMK: state_next.rdata[`FIC_EV_W-1:0] = state_reg.ev_mk;
                default: state_next.rdata = `FIC_ZERO32;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops, except o_irq, which ORs ev_st masked by ev_mk, and the combinational o_take above
    assign o_rdata = state_reg.rdata;
    assign o_sys_reset_req = state_reg.sw_system_reset_bit;
    assign o_vec_valid = state_reg.vec_valid;
    assign o_vec_direct = state_reg.vec_direct;
    assign o_vec_addr = state_reg.vec_addr;
    assign o_irq = |(state_reg.ev_st & state_reg.ev_mk);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    thr_block_a: assert property (o_take |-> !((thr_full != 8'h00) && (i_req_prio < thr_full))) // RULE_01
        else $error("request offered below threshold");

    thr_off_a: assert property ((state_reg.thr == 3'h0) && i_req_valid && !nest_full |-> o_take) // RULE_02
        else $error("zero threshold still held a request");

    thr_low_a: assert property (i_rd && (i_addr == `FIC_OFF_THR) |=> (o_rdata[4:0] == 5'h00)) // RULE_03
        else $error("threshold low bits not zero");

    key_guard_a: assert property (wr_cfg && !unlock_value_three_ok |=> !o_sys_reset_req) // RULE_04
        else $error("reset without correct key");

    key_read_a: assert property (i_rd && (i_addr == `FIC_OFF_CFG) |=> (o_rdata == 32'h0)) // RULE_05
        else $error("config read not zero");

    // Pulse follows exactly one keyed write with the reset bit set
    rst_pulse_a: assert property (o_sys_reset_req == (wr_cfg_d && unlock_value_three_d && bit7_d)) // RULE_06
        else $error("system reset pulse wrong");

    rst_clear_a: assert property (o_sys_reset_req && !wr_cfg |=> !o_sys_reset_req) // RULE_06
        else $error("system reset bit did not self clear");

    rst_zero_a: assert property (wr_cfg && !i_wdata[`FIC_SW_SYSTEM_RESET_BIT_BIT] |=> !o_sys_reset_req) // RULE_07
        else $error("zero write caused reset");

    pend_flag_a: assert property (i_rd && (i_addr == `FIC_OFF_GSR)
        |=> (o_rdata[9] == $past(i_any_pending))) // RULE_08
        else $error("pending flag wrong");

    act_flag_a: assert property (i_rd && (i_addr == `FIC_OFF_GSR)
        |=> (o_rdata[8] == $past(active))) // RULE_09
        else $error("active flag wrong");

    nest_cap_a: assert property (nest_full |-> !o_take) // RULE_10
        else $error("offer at full nesting");

    // An entry forced at full depth must not produce a vector
    full_novec_a: assert property (i_core_enter && nest_full |=> !o_vec_valid) // RULE_10
        else $error("vector given beyond two levels");

    nest_code_a: assert property (i_rd && (i_addr == `FIC_OFF_GSR) |=> (o_rdata[7:0] ==
        (($past(state_reg.nest) == FIC_NEST_TWO) ? 8'h03 :
         ($past(state_reg.nest) == FIC_NEST_ONE) ? 8'h01 : 8'h00))) // RULE_11
        else $error("nesting code wrong");

    ids_back_a: assert property (wr_ids ##1 (i_rd && (i_addr == `FIC_OFF_IDS) && !i_wr)
        |=> (o_rdata == $past(i_wdata, 2))) // RULE_12
        else $error("channel ids readback wrong");

    addr_lsb_a: assert property (o_vec_addr[0] == 1'b0) // RULE_13
        else $error("handler address odd");

    en_off_a: assert property (i_core_enter && !nest_full && !state_reg.en0 |=> !o_vec_direct) // RULE_14
        else $error("disabled channel used");

    direct_hit_a: assert property (i_core_enter && !nest_full && direct_hit
        |=> o_vec_valid && o_vec_direct && (o_vec_addr == {$past(state_reg.direct_ch0_handler_addr), 1'b0})) // RULE_15
        else $error("direct vector not supplied");

    // Non-matching entries fall back to the table with a zero address
    table_vec_a: assert property (i_core_enter && !nest_full && !direct_hit // RULE_15
        |=> o_vec_valid && !o_vec_direct && (o_vec_addr == `FIC_ZERO32))
        else $error("table entry flagged as direct");

    // A new hold-off lands in the status even when a read clears it
    thr_event_a: assert property (thr_blocked && !state_reg.blk_prev // RULE_01
        |=> state_reg.ev_st[`FIC_EV_THR])
        else $error("hold-off event lost");

    // Delayed copies for the reset pulse check
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_cfg_d <= 1'b0;
            unlock_value_three_d <= 1'b0;
            bit7_d <= 1'b0;
        end else begin
            wr_cfg_d <= wr_cfg;
            unlock_value_three_d <= unlock_value_three_ok;
            bit7_d <= i_wdata[`FIC_SW_SYSTEM_RESET_BIT_BIT];
        end
    end

    cov_reset_c: cover property (wr_cfg && unlock_value_three_ok && i_wdata[7] ##1 o_sys_reset_req);
    cov_nest2_c: cover property (state_reg.nest == FIC_NEST_TWO);
    cov_thr_c: cover property (thr_blocked);
    cov_direct_c: cover property (o_vec_direct ##0 o_vec_valid);
    cov_irq_c: cover property (o_irq ##1 rd_evst);

endmodule : fic_ctrl

// file: design/fic_defs.svh
`ifndef FIC_DEFS_SVH
`define FIC_DEFS_SVH

// ==========================================================
// Bus geometry
`define FIC_AW 8
`define FIC_DW 32

// ==========================================================
// Register byte offsets
`define FIC_OFF_THR 8'h40
`define FIC_OFF_CFG 8'h48
`define FIC_OFF_GSR 8'h4c
`define FIC_OFF_IDS 8'h50
`define FIC_OFF_ADR0 8'h60
`define FIC_OFF_EVST 8'h70
`define FIC_OFF_EVMK 8'h74

// ==========================================================
// Field positions and values
`define FIC_THR_HI 7
`define FIC_THR_LO 5
`define FIC_THR_W 3
`define FIC_THR_PAD 5'h00
`define FIC_KEY_HI 31
`define FIC_KEY_LO 16
`define FIC_KEY_ONE 16'hfa05
`define FIC_KEY_TWO 16'hbcaf
`define FIC_KEY_THREE 16'hbeef
`define FIC_SW_SYSTEM_RESET_BIT_BIT 7
`define FIC_EN0_BIT 0
`define FIC_GSR_PEND_BIT 9
`define FIC_GSR_ACT_BIT 8
`define FIC_NEST_NONE 8'h00
`define FIC_NEST_L1 8'h01
`define FIC_NEST_L2 8'h03
`define FIC_ID_W 8
`define FIC_EV_W 3
`define FIC_EV_THR 0
`define FIC_EV_DIRECT 1
`define FIC_EV_FULL 2
`define FIC_ZERO32 32'h0000_0000
`define FIC_ZERO_EV 3'h0

`endif

// file: design/fic_pkg.sv
`include "fic_defs.svh"

package fic_pkg;
    // Nesting depth of the context stack; two entries deep
    typedef enum logic [1:0] {
        FIC_NEST_IDLE = 2'b00,
        FIC_NEST_ONE  = 2'b01,
        FIC_NEST_TWO  = 2'b10
    } fic_nest_t;

    // Whole state of the controller
    typedef struct packed {
        logic [`FIC_THR_W-1:0] thr;
        logic [`FIC_DW-1:0] ids;
        logic [`FIC_DW-1:1] direct_ch0_handler_addr;
        logic en0;
        fic_nest_t nest;
        logic [`FIC_EV_W-1:0] ev_st;
        logic [`FIC_EV_W-1:0] ev_mk;
        logic blk_prev;
        logic [`FIC_DW-1:0] rdata;
        logic sw_system_reset_bit;
        logic vec_valid;
        logic vec_direct;
        logic [`FIC_DW-1:0] vec_addr;
    } fic_state_t;
endpackage : fic_pkg

// file: dv/fic_core_model.sv
`include "fic_defs.svh"

// ==========================================
// Core model: enters and leaves handlers on command
module fic_core_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Controller side
    input wire logic i_take,
    input wire logic i_vec_valid,
    input wire logic i_vec_direct,
    input wire logic [`FIC_DW-1:0] i_vec_addr,
    // Bench commands
    input wire logic i_want_enter,
    input wire logic i_want_exit,
    input wire logic i_force,
    // Pulses to the controller and last direct jump target
    output logic o_enter,
    output logic o_exit,
    output logic [`FIC_DW-1:0] o_jump_addr
);
    timeunit 1ns;
    timeprecision 100ps;

    // Enters only while a take is offered, unless told to misbehave on purpose
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_enter <= 1'b0;
            o_exit <= 1'b0;
            o_jump_addr <= `FIC_ZERO32;
        end else begin
            o_enter <= i_want_enter && (i_take || i_force);
            o_exit <= i_want_exit;
            if (i_vec_valid && i_vec_direct) begin
                o_jump_addr <= i_vec_addr;
            end
        end
    end
endmodule : fic_core_model

// file: dv/irq_threshold_status_vtf_cfg_bench.sv
`include "fic_defs.svh"

module irq_threshold_status_vtf_cfg_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, wr, rd, pend, rv, cen, cex, take, vv, vd, srr, irq;
    logic want_en, want_ex, force_en;
    logic [7:0] addr, rnum, rprio;
    logic [31:0] wdata, rdata, va, jump;
    int error_cnt = 0;
    int cmp_count = 0;

    // 250 MHz
    initial clk = 1'b0;
    always #2 clk = ~clk;

    fic_ctrl uut (
        .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_any_pending(pend), .i_req_valid(rv),
        .i_req_num(rnum), .i_req_prio(rprio), .o_take(take), .i_core_enter(cen),
        .i_core_exit(cex), .o_vec_valid(vv), .o_vec_direct(vd), .o_vec_addr(va),
        .o_sys_reset_req(srr), .o_irq(irq));
    fic_core_model core (
        .i_clk(clk), .i_rst(rst), .i_take(take), .i_vec_valid(vv), .i_vec_direct(vd),
        .i_vec_addr(va), .i_want_enter(want_en), .i_want_exit(want_ex),
        .i_force(force_en), .o_enter(cen), .o_exit(cex), .o_jump_addr(jump));

    // ==========================================
    // Shared tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(name, rdata, exp);
    endtask : rdc
    task automatic rst_pulses(input logic [31:0] exp);
        logic [31:0] n;
        n = 32'h0;
        repeat (4) begin
            #1;
            n = n + {31'h0, srr};
            @(posedge clk);
        end
        chk("reset request cycles", n, exp);
    endtask : rst_pulses
    task automatic take_is(input logic [7:0] p, input logic exp);
        @(posedge clk);
        rprio <= p;
        #1;
        chk("take", {31'h0, take}, {31'h0, exp});
    endtask : take_is
    task automatic enter(input logic f, input logic exp_vv);
        @(posedge clk);
        want_en <= 1'b1;
        force_en <= f;
        @(posedge clk);
        want_en <= 1'b0;
        @(posedge clk);
        #1;
        chk("vector valid", {31'h0, vv}, {31'h0, exp_vv});
    endtask : enter
    task automatic leave();
        @(posedge clk);
        want_ex <= 1'b1;
        @(posedge clk);
        want_ex <= 1'b0;
        @(posedge clk);
    endtask : leave

    // ==========================================
    // Scenarios
    task automatic t_reset();
        #1;
        chk("idle outputs", {28'h0, vv, srr, irq, take}, `FIC_ZERO32);
        rdc("threshold", `FIC_OFF_THR, `FIC_ZERO32);
        rdc("config", `FIC_OFF_CFG, `FIC_ZERO32);
        rdc("status", `FIC_OFF_GSR, `FIC_ZERO32);
        rdc("ids", `FIC_OFF_IDS, `FIC_ZERO32);
        rdc("address", `FIC_OFF_ADR0, `FIC_ZERO32);
        rdc("unmapped", 8'h44, `FIC_ZERO32);
    endtask : t_reset
    task automatic t_thresh();
        bus_wr(`FIC_OFF_THR, 32'hffff_ffff);
        rdc("threshold", `FIC_OFF_THR, 32'h0000_00e0);
        bus_wr(`FIC_OFF_THR, 32'h0000_0060);
        bus_wr(`FIC_OFF_EVMK, 32'h0000_0001);
        rv <= 1'b1;
        take_is(8'h5f, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        chk("irq on hold-off", {31'h0, irq}, 32'h1);
        rdc("events", `FIC_OFF_EVST, 32'h1);
        take_is(8'h60, 1'b1);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        bus_wr(`FIC_OFF_THR, 32'h0000_001f);
        rdc("threshold", `FIC_OFF_THR, `FIC_ZERO32);
        take_is(8'h00, 1'b1);
        // Masked event still latches but must not raise the line
        bus_wr(`FIC_OFF_EVMK, `FIC_ZERO32);
        bus_wr(`FIC_OFF_THR, 32'h0000_0060);
        repeat (2) @(posedge clk);
        #1;
        chk("irq masked", {31'h0, irq}, 32'h0);
        rdc("events", `FIC_OFF_EVST, 32'h1);
        @(posedge clk);
        rv <= 1'b0;
        bus_wr(`FIC_OFF_THR, `FIC_ZERO32);
    endtask : t_thresh
    task automatic t_cfg();
        bus_wr(`FIC_OFF_CFG, {`FIC_KEY_ONE, 16'h0080});
        rst_pulses(32'h0);
        bus_wr(`FIC_OFF_CFG, {`FIC_KEY_TWO, 16'h0080});
        rst_pulses(32'h0);
        bus_wr(`FIC_OFF_CFG, {`FIC_KEY_THREE, 16'h0000});
        rst_pulses(32'h0);
        bus_wr(`FIC_OFF_CFG, {`FIC_KEY_THREE, 16'h0080});
        rst_pulses(32'h1);
        rdc("config", `FIC_OFF_CFG, `FIC_ZERO32);
    endtask : t_cfg
    task automatic t_nest();
        @(posedge clk);
        pend <= 1'b1;
        rdc("pending", `FIC_OFF_GSR, 32'h0000_0200);
        @(posedge clk);
        pend <= 1'b0;
        rv <= 1'b1;
        rnum <= 8'h22;
        // Write then read with no gap between the strobes
        @(posedge clk);
        addr <= `FIC_OFF_IDS;
        wdata <= 32'h4433_2211;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("ids", rdata, 32'h4433_2211);
        enter(1'b0, 1'b1);
        chk("table vector", {31'h0, vd}, 32'h0);
        rdc("level one", `FIC_OFF_GSR, 32'h0000_0101);
        enter(1'b0, 1'b1);
        rdc("level two", `FIC_OFF_GSR, 32'h0000_0103);
        chk("take at two", {31'h0, take}, 32'h0);
        enter(1'b1, 1'b0);
        rdc("still two", `FIC_OFF_GSR, 32'h0000_0103);
        leave();
        rdc("back to one", `FIC_OFF_GSR, 32'h0000_0101);
        leave();
        leave();
        rdc("idle", `FIC_OFF_GSR, `FIC_ZERO32);
    endtask : t_nest
    task automatic t_direct();
        bus_wr(`FIC_OFF_ADR0, 32'h1234_5679);
        rdc("address", `FIC_OFF_ADR0, 32'h1234_5679);
        bus_wr(`FIC_OFF_EVMK, 32'h0000_0002);
        @(posedge clk);
        rnum <= 8'h11;
        enter(1'b0, 1'b1);
        chk("direct flag", {31'h0, vd}, 32'h1);
        chk("direct address", va, 32'h1234_5678);
        @(posedge clk);
        #1;
        chk("core jump", jump, 32'h1234_5678);
        chk("irq on entry", {31'h0, irq}, 32'h1);
        rdc("events", `FIC_OFF_EVST, 32'h0000_0006);
        @(posedge clk);
        #1;
        chk("irq cleared", {31'h0, irq}, 32'h0);
        leave();
        bus_wr(`FIC_OFF_ADR0, 32'h1234_5678);
        enter(1'b0, 1'b1);
        chk("disabled flag", {31'h0, vd}, 32'h0);
        chk("disabled address", va, `FIC_ZERO32);
        // Entry and exit in one cycle keep the depth
        @(posedge clk);
        want_en <= 1'b1;
        want_ex <= 1'b1;
        @(posedge clk);
        want_en <= 1'b0;
        want_ex <= 1'b0;
        @(posedge clk);
        rdc("enter and exit", `FIC_OFF_GSR, 32'h0000_0101);
        leave();
    endtask : t_direct
    // Reset in mid-run returns threshold, address and ids to zero
    task automatic t_rerst();
        bus_wr(`FIC_OFF_THR, 32'h0000_00a0);
        bus_wr(`FIC_OFF_ADR0, 32'h1234_5679);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc("threshold after reset", `FIC_OFF_THR, `FIC_ZERO32);
        rdc("address after reset", `FIC_OFF_ADR0, `FIC_ZERO32);
        rdc("ids after reset", `FIC_OFF_IDS, `FIC_ZERO32);
    endtask : t_rerst

    task automatic results();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        pend = 1'b0;
        rv = 1'b0;
        rnum = 8'h00;
        rprio = 8'h00;
        want_en = 1'b0;
        want_ex = 1'b0;
        force_en = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_thresh();
        t_cfg();
        t_nest();
        t_direct();
        t_rerst();
        results();
    end
    // Watchdog: the run needs well under a thousand cycles
    initial begin
        #20000;
        error_cnt++;
        results();
    end
endmodule : irq_threshold_status_vtf_cfg_bench
